/* verilog/smcc_core.v */
`timescale 1ns/100ps
`include "smcc_defs.vh"

// ------------------------------------------------
// Receive byte buffer
// ------------------------------------------------
module smcc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             sys_clk_i,
  input  wire             rstn_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wp_reg;
  reg [AW:0]      rp_reg;
  wire            full;
  wire            empty;

  assign full        = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  assign empty       = (wp_reg == rp_reg);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem[rp_reg[AW-1:0]];

  always @(posedge sys_clk_i) begin
    if (in_valid_i && !full) begin
      mem[wp_reg[AW-1:0]] <= in_data_i;
    end
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_reg <= {(AW+1){1'b0}};
      rp_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid_i && !full) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (out_ready_i && !empty) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule

// ------------------------------------------------
// Two-wire bus configuration and control core
// ------------------------------------------------
module smcc_core (
  input  wire       sys_clk_i,
  input  wire       rstn_i,
  input  wire [7:0] sfr_addr_i,
  input  wire       sfr_wr_i,
  input  wire       sfr_rd_i,
  input  wire [7:0] sfr_wdata_i,
  output reg  [7:0] sfr_rdata_o,
  input  wire       t0_ovf_i,
  input  wire       t1_ovf_i,
  input  wire       t2h_ovf_i,
  input  wire       t2l_ovf_i,
  input  wire       t3_split_i,
  output wire       t3_reload_hi_o,
  output wire       t3_reload_lo_o,
  output wire       bus_irq_o,
  input  wire       scl_i,
  output wire       scl_o,
  output wire       scl_oe_o,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_o
);
  localparam S_IDLE  = 6'h01;
  localparam S_START = 6'h02;
  localparam S_LOW   = 6'h04;
  localparam S_HIGH  = 6'h08;
  localparam S_STOP  = 6'h10;
  localparam S_WAIT  = 6'h20;

  // ------------------------------------------------
  // State
  // ------------------------------------------------
  reg [7:0] cfg_reg;
  reg       busy_reg;
  reg       master_reg;
  reg       tx_reg;
  reg       begin_reg;
  reg       halt_reg;
  reg       ack_needed_reg;
  reg       lost_reg;
  reg       ack_reg;
  reg       si_reg;
  reg       auto_reg;
  reg [7:0] own_reg;
  reg [5:0] state_reg;
  reg [1:0] ph_reg;
  reg [4:0] cnt_reg;
  reg [1:0] tcnt_reg;
  reg [3:0] fcnt_reg;
  reg [3:0] bit_reg;
  reg [7:0] shreg_reg;
  reg       addr_ph_reg;
  reg       addr_ok_reg;
  reg       rw_reg;
  reg       ignore_reg;
  reg       mute_eff_reg;
  reg       pend_push_reg;
  reg       scl_pull_reg;
  reg       sda_pull_reg;
  reg [2:0] scl_sync_reg;
  reg [2:0] sda_sync_reg;
  reg       tick;

  wire       on       = cfg_reg[`SMCC_CFG_ON];
  wire       stretch  = cfg_reg[`SMCC_CFG_STRETCH];
  wire [4:0] hold     = stretch ? `SMCC_HOLD_EXT : `SMCC_HOLD_STD;
  wire [4:0] hs       = hold + (stretch ? `SMCC_SETUP_EXT : `SMCC_SETUP_STD);
  wire       scl_hi   = scl_sync_reg[1];
  wire       sda_hi   = sda_sync_reg[1];
  wire       scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
  wire       scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
  wire       both_hi  = scl_sync_reg[1] & scl_sync_reg[2];
  wire       start_det = both_hi & ~sda_sync_reg[1] & sda_sync_reg[2];
  wire       stop_det  = both_hi & sda_sync_reg[1] & ~sda_sync_reg[2];
  wire       slot     = (bit_reg == 4'h8);
  wire       ticks_ok = (tcnt_reg >= `SMCC_PHASE_TICKS);
  wire       match    = (shreg_reg[6:0] == own_reg[7:1]);
  wire       slave_rx_addr = addr_ph_reg & ~master_reg & ~tx_reg;
  wire       no_slave = slave_rx_addr & (mute_eff_reg | (auto_reg & ~match));
  wire       ack_send = ~ignore_reg & ~(addr_ph_reg & mute_eff_reg) &
                        ((slave_rx_addr & auto_reg) ? addr_ok_reg : ack_reg);
  wire       drive_low = slot ? (~tx_reg & ack_send) : (tx_reg & ~shreg_reg[7]);
  wire       bit_end  = master_reg ? (scl_hi & ticks_ok) : scl_fall;
  wire       wr_ctl   = sfr_wr_i && (sfr_addr_i == `SMCC_CTL_ADDR);
  wire       rd_dat   = sfr_rd_i && (sfr_addr_i == `SMCC_DAT_ADDR);
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;

  // ------------------------------------------------
  // Tick select and pin outputs
  // ------------------------------------------------
  always @* begin
    case (cfg_reg[1:0])
      2'h0:    tick = t0_ovf_i;
      2'h1:    tick = t1_ovf_i;
      2'h2:    tick = t2h_ovf_i;
      default: tick = t2l_ovf_i;
    endcase
  end

  // Split mode keeps the low byte free for other users
  assign t3_reload_hi_o = on & cfg_reg[`SMCC_CFG_WATCH] & scl_hi;
  assign t3_reload_lo_o = t3_reload_hi_o & ~t3_split_i;
  assign bus_irq_o      = si_reg;
  assign scl_o          = 1'b0;
  assign sda_o          = 1'b0;
  assign scl_oe_o       = on & scl_pull_reg;
  assign sda_oe_o       = on & sda_pull_reg;

  smcc_fifo #(
    .WIDTH (8),
    .DEPTH (8),
    .AW    (3)
  ) u_rx_fifo (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (pend_push_reg),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (shreg_reg),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (rd_dat),
    .out_data_o  (fifo_out_data)
  );

  // ------------------------------------------------
  // Registers and bus engine
  // ------------------------------------------------
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg        <= `SMCC_CFG_RESET;
      busy_reg       <= 1'b0;
      master_reg     <= 1'b0;
      tx_reg         <= 1'b0;
      begin_reg      <= 1'b0;
      halt_reg       <= 1'b0;
      ack_needed_reg <= 1'b0;
      lost_reg       <= 1'b0;
      ack_reg        <= 1'b0;
      si_reg         <= 1'b0;
      auto_reg       <= 1'b0;
      own_reg        <= 8'h00;
      state_reg      <= S_IDLE;
      ph_reg         <= 2'h0;
      cnt_reg        <= 5'h00;
      tcnt_reg       <= 2'h0;
      fcnt_reg       <= 4'h0;
      bit_reg        <= 4'h0;
      shreg_reg      <= 8'h00;
      addr_ph_reg    <= 1'b0;
      addr_ok_reg    <= 1'b0;
      rw_reg         <= 1'b0;
      ignore_reg     <= 1'b0;
      mute_eff_reg   <= 1'b0;
      pend_push_reg  <= 1'b0;
      scl_pull_reg   <= 1'b0;
      sda_pull_reg   <= 1'b0;
      scl_sync_reg   <= 3'h7;
      sda_sync_reg   <= 3'h7;
      sfr_rdata_o    <= 8'h00;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      // Register writes first so hardware sets below win
      if (sfr_wr_i && sfr_addr_i == `SMCC_CFG_ADDR) begin
        cfg_reg <= {sfr_wdata_i[7:6], 1'b0, sfr_wdata_i[4:0]};
      end
      if (wr_ctl) begin
        begin_reg <= sfr_wdata_i[`SMCC_CTL_BEGIN];
        halt_reg  <= sfr_wdata_i[`SMCC_CTL_HALT];
        ack_reg   <= sfr_wdata_i[`SMCC_CTL_ACK];
        si_reg    <= sfr_wdata_i[`SMCC_CTL_SI];
        if (si_reg && !sfr_wdata_i[`SMCC_CTL_SI]) begin
          lost_reg       <= 1'b0;
          ack_needed_reg <= 1'b0;
        end
      end
      if (sfr_wr_i && sfr_addr_i == `SMCC_DAT_ADDR) begin
        shreg_reg <= sfr_wdata_i;
      end
      if (sfr_wr_i && sfr_addr_i == `SMCC_ADM_ADDR) begin
        auto_reg <= sfr_wdata_i[0];
      end
      if (sfr_wr_i && sfr_addr_i == `SMCC_OWN_ADDR) begin
        own_reg <= sfr_wdata_i;
      end
      if (sfr_rd_i) begin
        case (sfr_addr_i)
          `SMCC_CFG_ADDR: sfr_rdata_o <= {cfg_reg[7:6], busy_reg, cfg_reg[4:0]};
          `SMCC_CTL_ADDR: sfr_rdata_o <= {master_reg, tx_reg, begin_reg, halt_reg,
                                         ack_needed_reg, lost_reg, ack_reg, si_reg};
          `SMCC_DAT_ADDR: sfr_rdata_o <= fifo_out_valid ? fifo_out_data : 8'h00;
          `SMCC_ADM_ADDR: sfr_rdata_o <= {7'h00, auto_reg};
          `SMCC_OWN_ADDR: sfr_rdata_o <= own_reg;
          default:        sfr_rdata_o <= 8'h00;
        endcase
      end
      if (pend_push_reg && fifo_in_ready) begin
        pend_push_reg <= 1'b0;
      end
      if (cnt_reg != 5'h1f) begin
        cnt_reg <= cnt_reg + 5'h01;
      end
      if (tick && !ticks_ok) begin
        tcnt_reg <= tcnt_reg + 2'h1;
      end
      // Idle detect: more than ten ticks with both lines high
      if (cfg_reg[`SMCC_CFG_IDLE] && scl_hi && sda_hi) begin
        if (tick && fcnt_reg != 4'hf) begin
          fcnt_reg <= fcnt_reg + 4'h1;
        end
        if (fcnt_reg > `SMCC_FREE_TICKS) begin
          busy_reg <= 1'b0;
        end
      end else begin
        fcnt_reg <= 4'h0;
      end
      if (stop_det) begin
        busy_reg <= 1'b0;
        if (!master_reg && (state_reg & (S_LOW | S_HIGH | S_WAIT)) != 6'h00) begin
          halt_reg  <= 1'b1;
          si_reg    <= ~ignore_reg & ~mute_eff_reg;
          state_reg <= S_IDLE;
          scl_pull_reg <= 1'b0;
          sda_pull_reg <= 1'b0;
        end
      end
      // Mute is sampled at START so a running transfer keeps its interrupts
      if (start_det && !master_reg && state_reg != S_START && state_reg != S_STOP) begin
        busy_reg     <= 1'b1;
        begin_reg    <= 1'b1;
        mute_eff_reg <= cfg_reg[`SMCC_CFG_MUTE];
        ignore_reg   <= 1'b0;
        addr_ph_reg  <= 1'b1;
        tx_reg       <= 1'b0;
        bit_reg      <= 4'h0;
        cnt_reg      <= 5'h00;
        sda_pull_reg <= 1'b0;
        scl_pull_reg <= 1'b0;
        state_reg    <= S_LOW;
      end else begin
        case (state_reg)
          S_IDLE: begin
            if (begin_reg && !busy_reg && !si_reg) begin
              state_reg <= S_START;
              ph_reg    <= 2'h0;
              cnt_reg   <= 5'h00;
              tcnt_reg  <= 2'h0;
            end
          end
          S_START: begin
            case (ph_reg)
              2'h0: begin
                if (cnt_reg == hold) begin
                  sda_pull_reg <= 1'b0;
                end
                if (cnt_reg >= hs && ticks_ok) begin
                  scl_pull_reg <= 1'b0;
                  ph_reg       <= 2'h1;
                  tcnt_reg     <= 2'h0;
                end
              end
              2'h1: begin
                if (!scl_hi) begin
                  tcnt_reg <= 2'h0;
                end else if (ticks_ok) begin
                  sda_pull_reg <= 1'b1;
                  ph_reg       <= 2'h2;
                  tcnt_reg     <= 2'h0;
                end
              end
              default: begin
                if (ticks_ok) begin
                  scl_pull_reg <= 1'b1;
                  master_reg   <= 1'b1;
                  tx_reg       <= 1'b1;
                  begin_reg    <= 1'b1;
                  busy_reg     <= 1'b1;
                  si_reg       <= 1'b1;
                  addr_ph_reg  <= 1'b1;
                  bit_reg      <= 4'h0;
                  state_reg    <= S_WAIT;
                end
              end
            endcase
          end
          S_WAIT: begin
            scl_pull_reg <= 1'b1;
            if (ack_needed_reg) begin
              sda_pull_reg <= ack_reg & ~ignore_reg;
            end
            if (!si_reg) begin
              cnt_reg  <= 5'h00;
              tcnt_reg <= 2'h0;
              ph_reg   <= 2'h0;
              if (slot) begin
                if (slave_rx_addr && !ack_reg) begin
                  ignore_reg <= 1'b1;
                end
                state_reg <= S_LOW;
              end else if (master_reg && halt_reg) begin
                state_reg <= S_STOP;
              end else if (master_reg && begin_reg && !addr_ph_reg) begin
                state_reg <= S_START;
              end else begin
                state_reg <= S_LOW;
              end
            end
          end
          S_LOW: begin
            // A full receive buffer stretches SCL until a byte is read
            scl_pull_reg <= master_reg | pend_push_reg;
            if (cnt_reg == hold) begin
              sda_pull_reg <= drive_low;
            end
            if (!pend_push_reg && (master_reg ? (cnt_reg >= hs && ticks_ok) : scl_rise)) begin
              scl_pull_reg <= 1'b0;
              tcnt_reg     <= 2'h0;
              state_reg    <= S_HIGH;
            end
          end
          S_HIGH: begin
            if (master_reg && !scl_hi) begin
              tcnt_reg <= 2'h0;
            end
            if (bit_end) begin
              state_reg    <= S_LOW;
              cnt_reg      <= 5'h00;
              tcnt_reg     <= 2'h0;
              scl_pull_reg <= master_reg;
              if (!slot) begin
                shreg_reg <= {shreg_reg[6:0], sda_hi};
                bit_reg   <= bit_reg + 4'h1;
                if (tx_reg && !sda_pull_reg && !sda_hi) begin
                  lost_reg     <= 1'b1;
                  si_reg       <= 1'b1;
                  master_reg   <= 1'b0;
                  tx_reg       <= 1'b0;
                  scl_pull_reg <= 1'b0;
                  sda_pull_reg <= 1'b0;
                  state_reg    <= S_IDLE;
                end else if (bit_reg == 4'h7) begin
                  if (addr_ph_reg) begin
                    rw_reg <= tx_reg ? ~sda_pull_reg : sda_hi;
                  end
                  if (!tx_reg) begin
                    pend_push_reg <= ~no_slave;
                    addr_ok_reg   <= match;
                    if (no_slave) begin
                      ignore_reg <= 1'b1;
                    end else if (!auto_reg) begin
                      si_reg         <= 1'b1;
                      ack_needed_reg <= 1'b1;
                      ack_reg        <= 1'b0;
                      scl_pull_reg   <= 1'b1;
                      state_reg      <= S_WAIT;
                    end
                  end
                end
              end else begin
                bit_reg <= 4'h0;
                if (tx_reg) begin
                  ack_reg <= ~sda_hi;
                end
                if (addr_ph_reg) begin
                  addr_ph_reg <= 1'b0;
                  tx_reg      <= master_reg ? ~rw_reg : rw_reg;
                end
                if (!master_reg && ignore_reg) begin
                  scl_pull_reg <= 1'b0;
                  state_reg    <= S_IDLE;
                end else if (tx_reg || auto_reg) begin
                  si_reg       <= 1'b1;
                  scl_pull_reg <= 1'b1;
                  state_reg    <= S_WAIT;
                end else if (master_reg && halt_reg) begin
                  ph_reg    <= 2'h0;
                  state_reg <= S_STOP;
                end
              end
            end
          end
          S_STOP: begin
            if (ph_reg == 2'h0) begin
              scl_pull_reg <= 1'b1;
              if (cnt_reg == hold) begin
                sda_pull_reg <= 1'b1;
              end
              if (cnt_reg >= hs && ticks_ok) begin
                scl_pull_reg <= 1'b0;
                ph_reg       <= 2'h1;
                tcnt_reg     <= 2'h0;
              end
            end else if (!scl_hi) begin
              tcnt_reg <= 2'h0;
            end else if (ticks_ok) begin
              sda_pull_reg <= 1'b0;
              master_reg   <= 1'b0;
              tx_reg       <= 1'b0;
              halt_reg     <= 1'b0;
              ph_reg       <= 2'h0;
              cnt_reg      <= 5'h00;
              tcnt_reg     <= 2'h0;
              state_reg    <= begin_reg ? S_START : S_IDLE;
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
      if (!on) begin
        state_reg    <= S_IDLE;
        master_reg   <= 1'b0;
        tx_reg       <= 1'b0;
        busy_reg     <= 1'b0;
        scl_pull_reg <= 1'b0;
        sda_pull_reg <= 1'b0;
        addr_ph_reg  <= 1'b0;
        ignore_reg   <= 1'b0;
      end
    end
  end
endmodule

/* verilog/smcc_defs.vh */
// Function
// - Interface works only while interface_on is set; it watches SCL and SDA.
// - slave_mute suppresses slave interrupts; master interrupts still happen.
// - Busy bit sets during transfers, clears on STOP or idle timeout.
// - SCL-low watch holds Timer 3 reload while SCL high; split mode: high byte.
// - Idle detect frees the bus after SCL and SDA high over 10 ticks.
// - bit_clock_select picks Timer 0, Timer 1, Timer 2 high or low overflow.
// - sda_timing_stretch chooses normal or extended SDA setup and hold.
// - Extended: setup 11, hold 12 system clocks; normal hold 3 clocks.
// - Writing begin_cond_flag makes us master, START when free; not auto-cleared.
// - halt_cond_flag in master mode sends STOP after the next acknowledge cycle.
// - Both flags set in master mode give STOP then START.
// - Begin flag reports START seen or generated; halt flag STOP seen as slave, cleared after a sent STOP.
// - Top control bits show master and sending state of the transfer.
// - contention_lost sets on lost arbitration, clears when SI is cleared.
// - SI sets at a generated START, at a STOP seen as slave, per byte, on lost arbitration.
// - While SI is set in S_WAIT SCL is held low; lost arbitration and slave STOP set SI with SCL released.
// - Without auto ack, ack_needed sets on each received byte.
// - Software writes ACK before clearing SI, else a NACK goes out.
// - A written ACK value shows on SDA at once; SCL stays low.
// - When sending, the ACK bit holds the last received acknowledge.
// - Software NACK of own address ignores slave events until next START.
// - Auto ack matches addresses and sends ACK bit; ack_needed unused.
// - Auto NACKed address ignores slave events until START, no interrupt.
// - Muted slave NACKs all addresses, effective from the next START.
// - Master SCL low and high phases last at least one tick period.
`ifndef SMCC_DEFS_VH
`define SMCC_DEFS_VH
`define SMCC_CTL_ADDR     8'hc0
`define SMCC_CFG_ADDR     8'hc1
`define SMCC_DAT_ADDR     8'hc2
`define SMCC_ADM_ADDR     8'hc3
`define SMCC_OWN_ADDR     8'hc4
`define SMCC_CFG_RESET    8'h00
`define SMCC_CFG_ON       7
`define SMCC_CFG_MUTE     6
`define SMCC_CFG_BUSY     5
`define SMCC_CFG_STRETCH  4
`define SMCC_CFG_WATCH    3
`define SMCC_CFG_IDLE     2
`define SMCC_CTL_BEGIN    5
`define SMCC_CTL_HALT     4
`define SMCC_CTL_ACK      1
`define SMCC_CTL_SI       0
`define SMCC_HOLD_STD     5'h03
`define SMCC_HOLD_EXT     5'h0c
`define SMCC_SETUP_STD    5'h01
`define SMCC_SETUP_EXT    5'h0b
`define SMCC_FREE_TICKS   4'ha
`define SMCC_PHASE_TICKS  2'h2
`endif

/* tb/smcc_core_assertions.sv */
`timescale 1ns/100ps
// ----
// Port checker
// ----
module smcc_chk (
  input wire       sys_clk_i,
  input wire       rstn_i,
  input wire [7:0] sfr_addr_i,
  input wire       sfr_wr_i,
  input wire       sfr_rd_i,
  input wire [7:0] sfr_wdata_i,
  input wire [7:0] sfr_rdata_o,
  input wire       t3_split_i,
  input wire       t3_reload_hi_o,
  input wire       t3_reload_lo_o,
  input wire       bus_irq_o,
  input wire       scl_i,
  input wire       scl_oe_o,
  input wire       sda_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  reg [7:0] cfg_reg;
  // Shadow of the config register, same edge as the design
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      cfg_reg <= 8'h00;
    else if (sfr_wr_i && sfr_addr_i == 8'hc1)
      cfg_reg <= sfr_wdata_i;
  end
  sequence rd_at(a);
    sfr_rd_i && sfr_addr_i == a;
  endsequence
  sequence si_clr;
    sfr_wr_i && sfr_addr_i == 8'hc0 && !sfr_wdata_i[0];
  endsequence
  reload_split_a: assert property (t3_reload_lo_o == (t3_reload_hi_o && !t3_split_i))
    else $error("reload low byte wrong");
  scl_low_a: assert property ((!scl_i) [*4] |-> !t3_reload_hi_o)
    else $error("reload while scl low");
  off_idle_a: assert property (!cfg_reg[7] |->
    !scl_oe_o && !sda_oe_o && !t3_reload_hi_o)
    else $error("lines driven while off");
  scl_stall_a: assert property (cfg_reg[7] && bus_irq_o && $past(bus_irq_o) |->
    scl_oe_o)
    else $error("scl released during stall");
  si_clear_a: assert property (si_clr |=> !bus_irq_o)
    else $error("flag not cleared");
  lost_clear_a: assert property (si_clr ##[1:4] rd_at(8'hc0) |=>
    sfr_rdata_o[3:2] == 2'b00)
    else $error("lost or ack request kept");
  cfg_read_a: assert property (rd_at(8'hc1) |=>
    (sfr_rdata_o & 8'hdf) == ($past(cfg_reg) & 8'hdf))
    else $error("config readback wrong");
  si_view_a: assert property (rd_at(8'hc0) |=> sfr_rdata_o[0] == $past(bus_irq_o))
    else $error("flag readback wrong");
endmodule
bind smcc_core smcc_chk u_chk (.sys_clk_i, .rstn_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
  .sfr_wdata_i, .sfr_rdata_o, .t3_split_i, .t3_reload_hi_o, .t3_reload_lo_o, .bus_irq_o,
  .scl_i, .scl_oe_o, .sda_oe_o);

/* tb/smcc_slave_model.sv */
`timescale 1ns/100ps
// ----
// Slave on the bus
// ----
module smcc_slave_model #(
  parameter [6:0] DEV_ADDR = 7'h50
) (
  input  wire       scl_i,
  input  wire       sda_i,
  input  wire       slow_i,
  output reg        scl_pull_o = 1'b0,
  output reg        sda_pull_o = 1'b0,
  output reg  [7:0] last_byte_o = 8'h00,
  output reg        stop_seen_o = 1'b0
);
  reg [3:0] cnt = 4'hf;
  reg [7:0] sh = 8'h00;
  reg       first = 1'b1;
  reg       picked = 1'b0;
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      cnt = 4'h0;
      first = 1'b1;
      stop_seen_o = 1'b0;
    end
  end
  always @(posedge sda_i) begin
    if (scl_i === 1'b1)
      stop_seen_o = 1'b1;
  end
  always @(posedge scl_i) begin
    if (cnt < 4'h8) begin
      sh = {sh[6:0], sda_i};
      cnt = cnt + 4'h1;
    end
  end
  always @(negedge scl_i) begin
    if (sda_pull_o) begin
      sda_pull_o = 1'b0;
      cnt = 4'h0;
      // Slow part holds the low phase longer
      if (slow_i) begin
        scl_pull_o = 1'b1;
        #200 scl_pull_o = 1'b0;
      end
    end else if (cnt == 4'h8) begin
      if (first)
        picked = (sh[7:1] == DEV_ADDR);
      else
        last_byte_o = sh;
      first = 1'b0;
      sda_pull_o = picked;
      // Not addressed: deaf until next start
      if (!picked)
        cnt = 4'hf;
    end
  end
endmodule

/* tb/test_smcc_core.sv */
`timescale 1ns/100ps
module test_smcc_core;
  reg        sys_clk_i = 1'b0;
  reg        rstn_i = 1'b0;
  reg  [7:0] addr = 8'h00;
  reg        wr = 1'b0;
  reg        rd = 1'b0;
  reg  [7:0] wdata = 8'h00;
  reg  [3:0] tick = 4'h0;
  reg        split = 1'b0;
  reg        pin_low = 1'b0;
  reg        slow = 1'b0;
  wire [7:0] rdata;
  wire [7:0] got;
  wire       hi, lo, irq, scl_o, scl_oe, sda_o, sda_oe, s_scl, s_sda, stop_seen;
  wire       scl = ~((scl_oe & ~scl_o) | s_scl | pin_low);
  wire       sda = ~((sda_oe & ~sda_o) | s_sda);
  integer    fail_count = 0;
  integer    n_tests = 0;
  integer    cyc = 0;
  integer    i, k;
  always #2 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    tick <= tick + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      fail_count = fail_count + 1;
      give_verdict;
    end
  end
  smcc_core dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .t0_ovf_i(tick[1:0] == 2'h3),
    .t1_ovf_i(tick[2:0] == 3'h7), .t2h_ovf_i(tick == 4'hf), .t2l_ovf_i(tick[2:0] == 3'h5),
    .t3_split_i(split), .t3_reload_hi_o(hi), .t3_reload_lo_o(lo), .bus_irq_o(irq),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe));
  smcc_slave_model slave (.scl_i(scl), .sda_i(sda), .slow_i(slow), .scl_pull_o(s_scl),
    .sda_pull_o(s_sda), .last_byte_o(got), .stop_seen_o(stop_seen));
  task cmp(input [7:0] g, input [7:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk_i);
      wr <= 1'b0;
    end
  endtask
  task chk(input [7:0] a, input [7:0] m, input [7:0] e);
    begin
      @(posedge sys_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_i);
      rd <= 1'b0;
      #1 cmp(rdata & m, e);
    end
  endtask
  task wait_irq;
    begin
      // A clear written just before must reach the flag first
      @(posedge sys_clk_i);
      i = 0;
      while (irq !== 1'b1 && i < 4000) begin
        @(posedge sys_clk_i);
        i = i + 1;
      end
      cmp({7'h00, irq}, 8'h01);
    end
  endtask
  // Master write: start, address, one data byte if acked, stop
  task xfer(input [7:0] a, input [7:0] d, input ack);
    begin
      wr_reg(8'hc0, 8'h20);
      wait_irq;
      chk(8'hc0, 8'ha1, 8'ha1);
      chk(8'hc1, 8'h20, 8'h20);
      wr_reg(8'hc2, a);
      wr_reg(8'hc0, 8'h00);
      wait_irq;
      chk(8'hc0, 8'hc3, {6'h30, ack, 1'b1});
      if (ack) begin
        wr_reg(8'hc2, d);
        wr_reg(8'hc0, 8'h00);
        wait_irq;
        chk(8'hc0, 8'hc3, 8'hc3);
        cmp(got, d);
      end
      wr_reg(8'hc0, 8'h10);
      i = 0;
      while (stop_seen !== 1'b1 && i < 4000) begin
        @(posedge sys_clk_i);
        i = i + 1;
      end
      cmp({7'h00, stop_seen}, 8'h01);
      // Busy clears only after the pins pass the synchroniser
      repeat (4) @(posedge sys_clk_i);
      chk(8'hc1, 8'h20, 8'h00);
      chk(8'hc0, 8'h90, 8'h00);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    chk(8'hc1, 8'hff, 8'h00);
    chk(8'hc0, 8'hff, 8'h00);
    wr_reg(8'hc7, 8'hff);
    chk(8'hc7, 8'hff, 8'h00);
    wr_reg(8'hc4, 8'ha0);
    chk(8'hc4, 8'hfe, 8'ha0);
    for (k = 0; k < 4; k = k + 1) begin
      wr_reg(8'hc1, 8'hb8 | k[7:0]);
      chk(8'hc1, 8'hff, 8'h98 | k[7:0]);
    end
    #1 cmp({6'h00, hi, lo}, 8'h03);
    @(posedge sys_clk_i);
    split <= 1'b1;
    pin_low <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1 cmp({6'h00, hi, lo}, 8'h00);
    @(posedge sys_clk_i);
    split <= 1'b0;
    pin_low <= 1'b0;
    slow <= 1'b1;
    wr_reg(8'hc1, 8'h80);
    xfer(8'ha0, 8'h3c, 1'b1);
    slow <= 1'b0;
    wr_reg(8'hc1, 8'h9b);
    xfer(8'ha2, 8'h00, 1'b0);
    wr_reg(8'hc1, 8'h00);
    wr_reg(8'hc0, 8'h00);
    chk(8'hc0, 8'h80, 8'h00);
    give_verdict;
  end
endmodule
